// [hdl/hub_ccc_command_decoder.sv]
/*
 Host-bus command decoder: device-specific broadcast writes and the
 two-byte register/NVM command. Assumes a bus target on sys_clk_in that
 delivers start/stop/byte pulses, and bytes no closer than 9 clocks apart.
*/
// What this block does
// - Multicast writes act only on matching group code
// - Check byte covers command code onward, not address
// - Count byte upper field gives data bytes minus one
// - Further data bytes go to consecutive offsets
// - Two-byte commands only in I3C with checking
// - Length from second byte bits 7 to 5
// - Second byte bit 4 selects read or write
// - First byte bit 7 selects register or NVM
// - Block from both bytes, byte address from first byte
// - Scope code 011 compares group with identifier
// - Scope code 111 applies to every device
// - Scope codes other than 000, 011 and 111 are not acknowledged
`include "hub_ccc_defines.svh"

module hub_ccc_command_decoder (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Configuration
   input wire logic i3c_mode_in,
   input wire logic pec_enable_in,
   input wire logic [6:0] device_identifier_bits_in,
   // Byte stream
   input wire hub_ccc_pkg::frame_t frame_in,
   // Results
   output hub_ccc_pkg::reg_write_t reg_write_out,
   output hub_ccc_pkg::cmd_t cmd_out,
   output logic scope_nack_out,
   output logic pec_error_out,
   output logic cmd_reject_out
);
   import hub_ccc_pkg::*;

   typedef struct packed {
      state_t st;
      logic [7:0] crc;
      logic [2:0] scope;
      logic [7:0] offset;
      logic [2:0] count;
      logic [2:0] idx;
      logic [7:0][7:0] buffer;
      logic [7:0] byte1;
      logic by_start;
      reg_write_t wr;
      cmd_t cmd;
      logic nack;
      logic pec_err;
      logic reject;
   } core_t;

   core_t q;
   core_t d;
   logic [3:0] local_group_id;

   assign local_group_id = device_identifier_bits_in[6:3];

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ `HUB_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

   function automatic logic [4:0] len_of(input logic [2:0] code);
      case (code)
         `HUB_LEN_ONE: len_of = 5'h01;
         `HUB_LEN_TWO: len_of = 5'h02;
         `HUB_LEN_FOUR: len_of = 5'h04;
         `HUB_LEN_SIXTEEN: len_of = 5'h10;
         default: len_of = 5'h00;
      endcase
   endfunction

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      d = q;
      d.wr.valid = 1'b0;
      d.cmd.valid = 1'b0;
      d.nack = 1'b0;
      d.pec_err = 1'b0;
      d.reject = 1'b0;
      if (q.st == ST_DRAIN) begin
         // Writes held until the segment proved good, then replayed
         d.wr.valid = 1'b1;
         d.wr.offset = q.offset + {5'h00, q.idx};
         d.wr.data = q.buffer[q.idx];
         if (q.idx == q.count) begin
            d.st = q.by_start ? ST_ADDR : ST_IDLE;
            d.idx = 3'h0;
         end else begin
            d.idx = q.idx + 3'h1;
         end
      end else if (frame_in.start || frame_in.stop) begin
         d.crc = `HUB_CRC_INIT;
         d.idx = 3'h0;
         d.by_start = frame_in.start;
         if (q.st == ST_END) begin
            d.st = ST_DRAIN;
         end else begin
            d.st = frame_in.start ? ST_ADDR : ST_IDLE;
         end
      end else if (frame_in.valid) begin
         case (q.st)
            ST_ADDR: begin
               if (frame_in.data == `HUB_ADDR_BCAST_W) begin
                  d.st = ST_CODE;
               end else if (frame_in.data == {device_identifier_bits_in, 1'b0} && i3c_mode_in && pec_enable_in) begin
                  d.st = ST_CMD1;
               end else begin
                  d.st = ST_SKIP;
               end
            end
            ST_CODE: begin
               d.crc = crc8(q.crc, frame_in.data);
               d.st = (frame_in.data == `HUB_CCC_DEVCTRL) ? ST_SCOPE : ST_SKIP;
            end
            ST_SCOPE: begin
               d.crc = crc8(q.crc, frame_in.data);
               d.scope = frame_in.data[7:5];
               if (frame_in.data[7:5] != `HUB_SCOPE_UNI && frame_in.data[7:5] != `HUB_SCOPE_MULTI
                   && frame_in.data[7:5] != `HUB_SCOPE_BCAST) begin
                  d.nack = 1'b1;
                  d.st = ST_SKIP;
               end else begin
                  // General-register form is handled elsewhere
                  d.st = frame_in.data[0] ? ST_GROUP : ST_SKIP;
               end
            end
            ST_GROUP: begin
               d.crc = crc8(q.crc, frame_in.data);
               if (q.scope == `HUB_SCOPE_BCAST
                   || (q.scope == `HUB_SCOPE_MULTI && frame_in.data[7:4] == local_group_id)
                   || (q.scope == `HUB_SCOPE_UNI && frame_in.data[7:1] == device_identifier_bits_in)) begin
                  d.st = ST_OFFSET;
               end else begin
                  d.st = ST_SKIP;
               end
            end
            ST_OFFSET: begin
               d.crc = crc8(q.crc, frame_in.data);
               d.offset = frame_in.data;
               d.st = ST_COUNT;
            end
            ST_COUNT: begin
               d.crc = crc8(q.crc, frame_in.data);
               d.count = frame_in.data[7:5];
               d.idx = 3'h0;
               d.st = ST_DATA;
            end
            ST_DATA: begin
               d.crc = crc8(q.crc, frame_in.data);
               d.buffer[q.idx] = frame_in.data;
               if (q.idx == q.count) begin
                  d.idx = 3'h0;
                  d.st = pec_enable_in ? ST_PEC : ST_END;
               end else begin
                  d.idx = q.idx + 3'h1;
               end
            end
            ST_PEC: begin
               if (frame_in.data == q.crc) begin
                  d.st = ST_END;
               end else begin
                  d.pec_err = 1'b1;
                  d.st = ST_SKIP;
               end
            end
            ST_END: begin
               // Surplus bytes spoil the segment
               d.st = ST_SKIP;
            end
            ST_CMD1: begin
               d.byte1 = frame_in.data;
               d.st = ST_CMD2;
            end
            ST_CMD2: begin
               d.st = ST_SKIP;
               if (frame_in.data[7]) begin
                  d.reject = 1'b1;
               end else begin
                  d.cmd.valid = 1'b1;
                  d.cmd.len_code = frame_in.data[7:5];
                  d.cmd.len_bytes = len_of(frame_in.data[7:5]);
                  d.cmd.read = frame_in.data[4];
                  d.cmd.nvm = q.byte1[7];
                  d.cmd.block = {frame_in.data[3:0], q.byte1[6]};
                  d.cmd.byte_addr = q.byte1[5:0];
               end
            end
            default: d.st = q.st;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign reg_write_out = q.wr;
   assign cmd_out = q.cmd;
   assign scope_nack_out = q.nack;
   assign pec_error_out = q.pec_err;
   assign cmd_reject_out = q.reject;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   crc_restart_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      frame_in.start && q.st != ST_DRAIN && q.st != ST_END |=> q.crc == `HUB_CRC_INIT && q.st == ST_ADDR)
      else $error("check byte not restarted at start");
   first_offset_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      reg_write_out.valid && !$past(reg_write_out.valid) |-> reg_write_out.offset == q.offset)
      else $error("first write not at given offset");
   next_offset_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      reg_write_out.valid && $past(reg_write_out.valid) |-> reg_write_out.offset == $past(reg_write_out.offset) + 8'h01)
      else $error("write offsets not consecutive");
   cmd_gate_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      q.st == ST_CMD1 && $past(q.st) == ST_ADDR |-> $past(i3c_mode_in && pec_enable_in))
      else $error("command decoded outside checked I3C mode");
   cmd_length_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      cmd_out.valid |-> cmd_out.len_code == $past(frame_in.data[7:5]) && cmd_out.len_bytes != 5'h00)
      else $error("length code wrong");
   cmd_dir_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      cmd_out.valid |-> cmd_out.read == $past(frame_in.data[4]))
      else $error("direction bit wrong");
   cmd_space_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      cmd_out.valid |-> cmd_out.nvm == q.byte1[7])
      else $error("target space wrong");
   cmd_address_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      cmd_out.valid |-> cmd_out.block == {$past(frame_in.data[3:0]), q.byte1[6]} && cmd_out.byte_addr == q.byte1[5:0])
      else $error("address fields wrong");
   scope_nack_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      scope_nack_out |-> $past(q.st) == ST_SCOPE && $past(frame_in.data[7:5]) inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6})
      else $error("nack on a defined scope");
   pec_drop_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      pec_error_out |=> !reg_write_out.valid ##1 !reg_write_out.valid)
      else $error("writes kept after bad check byte");
   reserved_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      cmd_reject_out |-> $past(frame_in.data[7]) && !cmd_out.valid)
      else $error("reserved length not refused");

endmodule

// [hdl/hub_ccc_defines.svh]
/*
 Constants for the host-bus command decoder: bus codes, field codes
 and check-byte polynomial. Assumes inclusion by the decoder.
*/
`ifndef HUB_CCC_DEFINES_SVH
`define HUB_CCC_DEFINES_SVH

// -----------------------------------------------------------------
// Bus codes
// -----------------------------------------------------------------
`define HUB_ADDR_BCAST_W 8'hFC
`define HUB_CCC_DEVCTRL 8'h62
`define HUB_CRC_POLY 8'h07
`define HUB_CRC_INIT 8'h00

// -----------------------------------------------------------------
// Target scope codes
// -----------------------------------------------------------------
`define HUB_SCOPE_UNI 3'h0
`define HUB_SCOPE_MULTI 3'h3
`define HUB_SCOPE_BCAST 3'h7

// -----------------------------------------------------------------
// Transfer length codes
// -----------------------------------------------------------------
`define HUB_LEN_ONE 3'h0
`define HUB_LEN_TWO 3'h1
`define HUB_LEN_FOUR 3'h2
`define HUB_LEN_SIXTEEN 3'h3

`endif

// [hdl/hub_ccc_pkg.sv]
/*
 Types shared by the host-bus command decoder and its surroundings.
 Assumes a byte-level bus target in front of it on the same clock.
*/
package hub_ccc_pkg;

   // -----------------------------------------------------------------
   // Byte stream from the bus target
   // -----------------------------------------------------------------
   typedef struct packed {
      logic start;
      logic stop;
      logic valid;
      logic [7:0] data;
   } frame_t;

   typedef struct packed {
      logic valid;
      logic [7:0] offset;
      logic [7:0] data;
   } reg_write_t;

   typedef struct packed {
      logic valid;
      logic [2:0] len_code;
      logic [4:0] len_bytes;
      logic read;
      logic nvm;
      logic [4:0] block;
      logic [5:0] byte_addr;
   } cmd_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_ADDR = 4'b0001,
      ST_CODE = 4'b0010,
      ST_SCOPE = 4'b0011,
      ST_GROUP = 4'b0100,
      ST_OFFSET = 4'b0101,
      ST_COUNT = 4'b0110,
      ST_DATA = 4'b0111,
      ST_PEC = 4'b1000,
      ST_END = 4'b1001,
      ST_CMD1 = 4'b1010,
      ST_CMD2 = 4'b1011,
      ST_SKIP = 4'b1100,
      ST_DRAIN = 4'b1101
   } state_t;

endpackage

// [verif/host_bus_model.sv]
/*
 Host controller model: sends start, stop and byte pulses to the decoder.
 Assumes one bench process calls its tasks, on the decoder's own clock.
*/
module host_bus_model (
   // Clock
   input wire logic sys_clk_in,
   // Byte stream
   output hub_ccc_pkg::frame_t frame_out
);
   timeunit 1ns;
   timeprecision 100ps;
   import hub_ccc_pkg::*;
   logic [7:0] crc;
   initial frame_out = '0;

   // ----------------------------------------------------------------
   // Pulses
   // ----------------------------------------------------------------
   // Idle data shows the inverse so a stale byte never looks fresh
   task automatic put(input logic [2:0] kind, input logic [7:0] d);
      @(posedge sys_clk_in);
      #1 frame_out = {kind, d};
      @(posedge sys_clk_in);
      #1 frame_out = {3'b000, ~d};
      repeat (9) @(posedge sys_clk_in);
   endtask

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
      return r;
   endfunction

   task automatic byte_c(input logic [7:0] d);
      crc = crc8(crc, d);
      put(3'b001, d);
   endtask

   // ----------------------------------------------------------------
   // Transfers
   // ----------------------------------------------------------------
   // Data byte i is d0+i; pec 0 none, 1 good, 2 spoiled
   task automatic segment(input logic [7:0] scope, grp, off, d0, input int n, pec);
      crc = 8'h00;
      put(3'b100, 8'h00);
      put(3'b001, 8'hFC);
      byte_c(8'h62);
      byte_c(scope);
      byte_c(grp);
      byte_c(off);
      byte_c({3'(n - 1), 5'h00});
      for (int i = 0; i < n; i++) byte_c(d0 + 8'(i));
      if (pec != 0) put(3'b001, pec == 1 ? crc : ~crc);
      put(3'b010, 8'h00);
   endtask

   task automatic command(input logic [7:0] addr, b1, b2);
      put(3'b100, 8'h00);
      put(3'b001, addr);
      put(3'b001, b1);
      put(3'b001, b2);
      put(3'b010, 8'h00);
   endtask
endmodule

// [verif/tb_top.sv]
/*
 Bench for the command decoder: notes expectations in a queue, a monitor
 compares each output pulse. Assumes the host model drives the stream.
*/
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import hub_ccc_pkg::*;
   logic sys_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic i3c_mode_in = 1'b1;
   logic pec_enable_in = 1'b1;
   logic [6:0] device_identifier_bits_in = 7'h13;
   frame_t frame_in;
   reg_write_t reg_write_out;
   cmd_t cmd_out;
   logic scope_nack_out, pec_error_out, cmd_reject_out;
   int bad_count = 0;
   int num_checks = 0;
   int seed = 25;
   logic [27:0] notes[$];

   host_bus_model i_host (.sys_clk_in(sys_clk_in), .frame_out(frame_in));
   hub_ccc_command_decoder i_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .i3c_mode_in(i3c_mode_in),
      .pec_enable_in(pec_enable_in), .device_identifier_bits_in(device_identifier_bits_in), .frame_in(frame_in),
      .reg_write_out(reg_write_out), .cmd_out(cmd_out), .scope_nack_out(scope_nack_out),
      .pec_error_out(pec_error_out), .cmd_reject_out(cmd_reject_out));

   initial forever #10 sys_clk_in = ~sys_clk_in;

   // ----------------------------------------------------------------
   // Comparison
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [27:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // An output with no note pending is compared against zero and fails
   task automatic take(input string what, input logic [27:0] seen);
      check(what, seen, notes.size() == 0 ? 28'h0 : notes.pop_front());
   endtask

   always @(posedge sys_clk_in) begin
      if (reg_write_out.valid === 1'b1) take("reg_write", {12'h100, reg_write_out.offset, reg_write_out.data});
      if (cmd_out.valid === 1'b1) take("cmd", {6'h08, cmd_out});
      if (scope_nack_out === 1'b1) take("scope_nack", 28'h3000000);
      if (pec_error_out === 1'b1) take("pec_error", 28'h4000000);
      if (cmd_reject_out === 1'b1) take("cmd_reject", 28'h5000000);
   end

   function automatic logic [27:0] cmd_note(input logic [7:0] b1, b2);
      cmd_t c;
      c.valid = 1'b1;
      c.len_code = b2[7:5];
      c.len_bytes = 5'h01 << (b2[6:5] == 2'b11 ? 3'd4 : {1'b0, b2[6:5]});
      c.read = b2[4];
      c.nvm = b1[7];
      c.block = {b2[3:0], b1[6]};
      c.byte_addr = b1[5:0];
      return {6'h08, c};
   endfunction

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #(20 * 20000);
      bad_count++;
      tally_and_finish();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] sc, grp, off, d0, b1, b2;
      int n;
      logic [6:0] id;
      id = device_identifier_bits_in;
      repeat (10) @(posedge sys_clk_in);
      #1 reset_in = 1'b0;
      // Unicast, multicast, broadcast; matching then foreign group
      for (int k = 0; k < 6; k++) begin
         sc = k % 3 == 0 ? 8'h01 : (k % 3 == 1 ? 8'h61 : 8'hE1);
         grp = k % 3 == 0 ? {k < 3 ? id : ~id, 1'b0} : {k < 3 ? id[6:3] : ~id[6:3], 4'h0};
         n = 1 + ($random(seed) & 7);
         off = 8'($random(seed));
         d0 = 8'($random(seed));
         if (k < 3 || sc == 8'hE1) begin
            for (int i = 0; i < n; i++) notes.push_back({12'h100, off + 8'(i), d0 + 8'(i)});
         end
         i_host.segment(sc, grp, off, d0, n, 1);
      end
      notes.push_back(28'h4000000);
      i_host.segment(8'h61, {id[6:3], 4'h0}, 8'h15, 8'h78, 2, 2);
      for (int j = 1; j < 7; j++) begin
         if (j != 3) begin
            notes.push_back(28'h3000000);
            i_host.segment({3'(j), 5'h01}, {id[6:3], 4'h0}, 8'h10, 8'h01, 1, 1);
         end
      end
      for (int k = 0; k < 16; k++) begin
         b1 = 8'($random(seed));
         b2 = {3'(k), 5'($random(seed))};
         notes.push_back(b2[7] ? 28'h5000000 : cmd_note(b1, b2));
         i_host.command({id, 1'b0}, b1, b2);
      end
      #1 i3c_mode_in = 1'b0;
      i_host.command({id, 1'b0}, 8'h12, 8'h34);
      #1 i3c_mode_in = 1'b1;
      pec_enable_in = 1'b0;
      i_host.command({id, 1'b0}, 8'h56, 8'h78);
      // Without a check byte the segment still commits at its end
      notes.push_back({12'h100, 8'h40, 8'hA0});
      notes.push_back({12'h100, 8'h41, 8'hA1});
      i_host.segment(8'hE1, 8'h00, 8'h40, 8'hA0, 2, 0);
      repeat (30) @(posedge sys_clk_in);
      check("notes_left", 28'(notes.size()), 28'h0);
      tally_and_finish();
   end
endmodule
